// File: logic/ace_top.sv
// comparator event control: status/control register, event flag, interrupt, axi4-lite slave
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
module ace_top (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic COMPARATOR_RAW,
    output logic COMPARATOR_ENABLE,
    output logic REFERENCE_INPUT_SELECT,
    output logic COMPARATOR_OUTPUT_PIN,
    output logic COMPARATOR_OUTPUT_PIN_OE,
    output logic IRQ,
    input wire logic [ace_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ace_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import ace_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic enable_q;
        logic ref_sel_q;
        logic flag_q;
        logic irq_en_q;
        logic level_q;
        logic pin_en_q;
        logic [1:0] mode_q;
        logic [IRQ_BITS-1:0] ist_q;
        logic [IRQ_BITS-1:0] imask_q;
        logic pin_q;
        logic irq_q;
        ace_bus_state_t wst_q;
        ace_bus_state_t rst_q;
        logic aw_have_q;
        logic w_have_q;
        logic [ADDR_W-1:0] awaddr_q;
        logic [31:0] wdata_q;
        logic [3:0] wstrb_q;
        logic [1:0] bresp_q;
        logic [31:0] rdata_q;
        logic [1:0] rresp_q;
        logic awready_q;
        logic wready_q;
        logic bvalid_q;
        logic arready_q;
        logic rvalid_q;
    } ace_state_t;

    ace_state_t s_q, s_d;
    logic level_sync;
    logic event_pulse;
    logic rise_pulse;

    // ****************************************************************
    // comparator sampling
    // ****************************************************************
    ace_sync u_sync (
        .CLOCK(CLOCK),
        .RESETN(RESETN),
        .async_in(COMPARATOR_RAW),
        .sync_out(level_sync)
    );

    ace_edge u_edge (
        .CLOCK(CLOCK),
        .RESETN(RESETN),
        .level_in(level_sync),
        .enable(s_q.enable_q),
        .mode(s_q.mode_q),
        .event_pulse(event_pulse),
        .rise_pulse(rise_pulse)
    );

    function automatic logic [7:0] csc_read(input ace_state_t s);
        logic [7:0] v;
        v = CSC_RESET;
        v[BIT_ENABLE] = s.enable_q;
        v[BIT_REF_SEL] = s.ref_sel_q;
        v[BIT_FLAG] = s.flag_q;
        v[BIT_IRQ_EN] = s.irq_en_q;
        v[BIT_OUT_LEVEL] = s.level_q;
        v[BIT_PIN_EN] = s.pin_en_q;
        v[BIT_MODE_HI:BIT_MODE_LO] = s.mode_q;
        return v;
    endfunction : csc_read

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a == ADDR_STATUS_CONTROL) || (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
    endfunction : addr_ok

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic do_write;
        logic [7:0] wb;
        logic flag_clr;
        logic [IRQ_BITS-1:0] ist_clr;
        do_write = 1'b0;
        wb = s_q.wdata_q[7:0];
        flag_clr = 1'b0;
        ist_clr = '0;
        s_d = s_q;

        // write channel: address and data taken in either order
        case (s_q.wst_q)
            BUS_IDLE: begin
                if (S_AXI_AWVALID && !s_q.aw_have_q) begin
                    s_d.aw_have_q = 1'b1;
                    s_d.awaddr_q = S_AXI_AWADDR;
                end
                if (S_AXI_WVALID && !s_q.w_have_q) begin
                    s_d.w_have_q = 1'b1;
                    s_d.wdata_q = S_AXI_WDATA;
                    s_d.wstrb_q = S_AXI_WSTRB;
                end
                if (s_q.aw_have_q && s_q.w_have_q) begin
                    do_write = 1'b1;
                    s_d.aw_have_q = 1'b0;
                    s_d.w_have_q = 1'b0;
                    s_d.bresp_q = addr_ok(s_q.awaddr_q) ? RESP_OKAY : RESP_SLVERR;
                    s_d.wst_q = BUS_WRESP;
                end
            end
            BUS_WRESP: begin
                if (S_AXI_BREADY) begin
                    s_d.wst_q = BUS_IDLE;
                end
            end
            default: s_d.wst_q = BUS_IDLE;
        endcase

        // register writes, only the low byte lane carries data
        if (do_write && s_q.wstrb_q[0]) begin
            case (s_q.awaddr_q)
                ADDR_STATUS_CONTROL: begin
                    s_d.enable_q = wb[BIT_ENABLE];
                    s_d.ref_sel_q = wb[BIT_REF_SEL];
                    s_d.irq_en_q = wb[BIT_IRQ_EN];
                    s_d.pin_en_q = wb[BIT_PIN_EN];
                    s_d.mode_q = wb[BIT_MODE_HI:BIT_MODE_LO];
                    flag_clr = wb[BIT_FLAG];
                end
                ADDR_IRQ_STATUS: ist_clr = wb[IRQ_BITS-1:0];
                ADDR_IRQ_MASK: s_d.imask_q = wb[IRQ_BITS-1:0];
                default: ;
            endcase
        end

        // set wins over a clear in the same cycle
        s_d.flag_q = (s_q.flag_q & ~flag_clr) | event_pulse;
        s_d.ist_q[IRQ_EVENT] = (s_q.ist_q[IRQ_EVENT] & ~ist_clr[IRQ_EVENT]) | event_pulse;
        s_d.ist_q[IRQ_RISE] = (s_q.ist_q[IRQ_RISE] & ~ist_clr[IRQ_RISE]) | rise_pulse;

        // level reads zero while disabled
        s_d.level_q = s_q.enable_q & level_sync;
        s_d.pin_q = s_q.enable_q & s_q.pin_en_q & level_sync;
        s_d.irq_q = (s_d.flag_q & s_d.irq_en_q) | (|(s_d.ist_q & s_d.imask_q));

        // read channel
        case (s_q.rst_q)
            BUS_IDLE: begin
                if (S_AXI_ARVALID) begin
                    s_d.rresp_q = addr_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
                    case (S_AXI_ARADDR)
                        ADDR_STATUS_CONTROL: s_d.rdata_q = {24'h000000, csc_read(s_q)};
                        ADDR_IRQ_STATUS: s_d.rdata_q = {{(32-IRQ_BITS){1'b0}}, s_q.ist_q};
                        ADDR_IRQ_MASK: s_d.rdata_q = {{(32-IRQ_BITS){1'b0}}, s_q.imask_q};
                        default: s_d.rdata_q = 32'h00000000;
                    endcase
                    s_d.rst_q = BUS_RDATA;
                end
            end
            BUS_RDATA: begin
                if (S_AXI_RREADY) begin
                    s_d.rst_q = BUS_IDLE;
                end
            end
            default: s_d.rst_q = BUS_IDLE;
        endcase

        // handshake pins decoded from the next state so each one leaves a flop
        s_d.awready_q = (s_d.wst_q == BUS_IDLE) && !s_d.aw_have_q;
        s_d.wready_q = (s_d.wst_q == BUS_IDLE) && !s_d.w_have_q;
        s_d.bvalid_q = (s_d.wst_q == BUS_WRESP);
        s_d.arready_q = (s_d.rst_q == BUS_IDLE);
        s_d.rvalid_q = (s_d.rst_q == BUS_RDATA);
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            s_q <= '0;
            s_q.wst_q <= BUS_IDLE;
            s_q.rst_q <= BUS_IDLE;
            s_q.awready_q <= 1'b1;
            s_q.wready_q <= 1'b1;
            s_q.arready_q <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign COMPARATOR_ENABLE = s_q.enable_q;
    assign REFERENCE_INPUT_SELECT = s_q.ref_sel_q;
    assign COMPARATOR_OUTPUT_PIN = s_q.pin_q;
    assign COMPARATOR_OUTPUT_PIN_OE = s_q.pin_en_q;
    assign IRQ = s_q.irq_q;
    assign S_AXI_AWREADY = s_q.awready_q;
    assign S_AXI_WREADY = s_q.wready_q;
    assign S_AXI_BVALID = s_q.bvalid_q;
    assign S_AXI_BRESP = s_q.bresp_q;
    assign S_AXI_ARREADY = s_q.arready_q;
    assign S_AXI_RVALID = s_q.rvalid_q;
    assign S_AXI_RDATA = s_q.rdata_q;
    assign S_AXI_RRESP = s_q.rresp_q;
endmodule : ace_top

// File: logic/ace_pkg.sv
// package: register map, field layout and constants of the comparator event control block
package ace_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    localparam int ADDR_W = 4;
    // ****************************************************************
    // field positions of comparator_status_control
    // ****************************************************************
    localparam int BIT_ENABLE = 7;
    localparam int BIT_REF_SEL = 6;
    localparam int BIT_FLAG = 5;
    localparam int BIT_IRQ_EN = 4;
    localparam int BIT_OUT_LEVEL = 3;
    localparam int BIT_PIN_EN = 2;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_MODE_LO = 0;
    localparam logic [7:0] CSC_RESET = 8'h00;
    localparam logic [7:0] CSC_WRITE_MASK = 8'hd7;
    // ****************************************************************
    // event modes
    // ****************************************************************
    localparam logic [1:0] MODE_FALL_A = 2'h0;
    localparam logic [1:0] MODE_RISE = 2'h1;
    localparam logic [1:0] MODE_FALL_B = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;
    // ****************************************************************
    // bus answers, interrupt status bits and bus states
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int IRQ_BITS = 2;
    localparam int IRQ_EVENT = 0;
    localparam int IRQ_RISE = 1;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'h1,
        BUS_WRESP = 3'h2,
        BUS_RDATA = 3'h4
    } ace_bus_state_t;
endpackage : ace_pkg

// File: logic/ace_sync.sv
// two-flop synchroniser for the comparator output level
module ace_sync (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic meta_q;
        logic sync_q;
    } ace_sync_state_t;
    ace_sync_state_t s_q, s_d;
    // ****************************************************************
    // logic
    // ****************************************************************
    always_comb begin
        s_d.meta_q = async_in;
        s_d.sync_q = s_q.meta_q;
    end
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign sync_out = s_q.sync_q;
endmodule : ace_sync

// File: logic/ace_edge.sv
// edge detector choosing compare events by mode
module ace_edge (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic level_in,
    input wire logic enable,
    input wire logic [1:0] mode,
    output logic event_pulse,
    output logic rise_pulse
);
    import ace_pkg::*;
    typedef struct packed {
        logic prev_q;
    } ace_edge_state_t;
    ace_edge_state_t s_q, s_d;
    logic rise;
    logic fall;
    // ****************************************************************
    // logic
    // ****************************************************************
    always_comb begin
        // previous sample follows zero while disabled so a stale sample never fakes an edge
        s_d.prev_q = enable & level_in;
        rise = enable & level_in & ~s_q.prev_q;
        fall = enable & ~level_in & s_q.prev_q;
        case (mode)
            MODE_FALL_A: event_pulse = fall;
            MODE_RISE: event_pulse = rise;
            MODE_FALL_B: event_pulse = fall;
            MODE_BOTH: event_pulse = rise | fall;
            default: event_pulse = 1'b0;
        endcase
        rise_pulse = rise;
    end
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : ace_edge

// File: dv/ace_properties.sv
// checker: bus and pin properties of the comparator event control block
module ace_top_checker (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic COMPARATOR_RAW,
    input wire logic COMPARATOR_ENABLE,
    input wire logic REFERENCE_INPUT_SELECT,
    input wire logic COMPARATOR_OUTPUT_PIN,
    input wire logic COMPARATOR_OUTPUT_PIN_OE,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);
    // control outputs move only when a write commits
    property p_ctrl_commit;
        $changed({COMPARATOR_ENABLE, REFERENCE_INPUT_SELECT, COMPARATOR_OUTPUT_PIN_OE})
            |-> $rose(S_AXI_BVALID);
    endproperty
    a_ctrl_commit: assert property (p_ctrl_commit) else $error("control moved off commit");
    // three cycles of slack cover the registered pin path
    property p_pin_off;
        (!COMPARATOR_OUTPUT_PIN_OE || !COMPARATOR_ENABLE) [*3] |-> !COMPARATOR_OUTPUT_PIN;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("output pin driven while off");
    property p_pin_on;
        (COMPARATOR_OUTPUT_PIN_OE && COMPARATOR_ENABLE && COMPARATOR_RAW) [*5]
            |-> COMPARATOR_OUTPUT_PIN;
    endproperty
    a_pin_on: assert property (p_pin_on) else $error("output pin not following");
    property p_aw_taken;
        S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY;
    endproperty
    a_aw_taken: assert property (p_aw_taken) else $error("awready high after address");
    property p_bresp_time;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
    endproperty
    a_bresp_time: assert property (p_bresp_time) else $error("write answer late");
    property p_rd_time;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
    endproperty
    a_rd_time: assert property (p_rd_time) else $error("read answer late");
    property p_ar_block;
        S_AXI_RVALID |-> !S_AXI_ARREADY;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("arready high during answer");
    property p_rd_upper;
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
endmodule : ace_top_checker

bind ace_top ace_top_checker ace_top_checker_i (.CLOCK(CLOCK), .RESETN(RESETN),
    .COMPARATOR_RAW(COMPARATOR_RAW), .COMPARATOR_ENABLE(COMPARATOR_ENABLE),
    .REFERENCE_INPUT_SELECT(REFERENCE_INPUT_SELECT), .COMPARATOR_OUTPUT_PIN(COMPARATOR_OUTPUT_PIN),
    .COMPARATOR_OUTPUT_PIN_OE(COMPARATOR_OUTPUT_PIN_OE), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID));

// File: dv/ace_comparator_model.sv
// analog comparator core model driven by bench input levels
module ace_comparator_model (
    input wire logic enable,
    input wire logic ref_sel,
    input wire logic pin_level,
    input wire logic ref_level,
    output logic out_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // a disabled core sits low rather than float
    assign out_level = enable & (ref_sel ? ref_level : pin_level);
endmodule : ace_comparator_model

// File: dv/ace_top_bench.sv
// testbench: register sequences for the comparator event control block
module ace_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ace_pkg::*;
    logic clk = 0, rstn = 0, pin = 0, refl = 0, raw, en, rsel, opin, oe, irq;
    logic awv = 0, awr, wv = 0, wrdy, bv, br = 0, arv = 0, arr, rv, rr = 0;
    logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'hf;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0] bresp, rresp;
    int num_errors = 0, compares = 0, cyc = 0;
    always #10 clk = ~clk;
    ace_comparator_model ace_comparator_model_i (.enable(en), .ref_sel(rsel), .pin_level(pin),
        .ref_level(refl), .out_level(raw));
    ace_top ace_top_i (.CLOCK(clk), .RESETN(rstn), .COMPARATOR_RAW(raw), .COMPARATOR_ENABLE(en),
        .REFERENCE_INPUT_SELECT(rsel), .COMPARATOR_OUTPUT_PIN(opin),
        .COMPARATOR_OUTPUT_PIN_OE(oe), .IRQ(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
    task conclude;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // address and data leave together; each is dropped at its own handshake
    task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, dd;
        ad = 0;
        dd = 0;
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awr && !ad) begin
                ad = 1;
                awv <= 0;
            end
            if (wrdy && !dd) begin
                dd = 1;
                wv <= 0;
            end
        end
        br <= 1;
        do @(posedge clk); while (!bv);
        r = bresp;
        br <= 0;
    endtask : wr
    task rchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er, input string n);
        arv <= 1;
        ara <= a;
        do @(posedge clk); while (!arr);
        arv <= 0;
        rr <= 1;
        do @(posedge clk); while (!rv);
        rr <= 0;
        chk(n, e, rdat);
        chk(n, {30'h0, er}, {30'h0, rresp});
    endtask : rchk
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        logic [1:0] r;
        logic [31:0] x;
        repeat (3) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        rchk(ADDR_STATUS_CONTROL, {24'h0, CSC_RESET}, RESP_OKAY, "csc reset");
        rchk(4'hc, 32'h0, RESP_SLVERR, "unmapped rd");
        wr(4'hc, 32'hff, r);
        chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, r});
        // low byte lane off: the write is dropped but still answered
        ws <= 4'he;
        wr(ADDR_STATUS_CONTROL, 32'hd7, r);
        ws <= 4'hf;
        chk("strobe off resp", {30'h0, RESP_OKAY}, {30'h0, r});
        rchk(ADDR_STATUS_CONTROL, {24'h0, CSC_RESET}, RESP_OKAY, "strobe off");
        wr(ADDR_STATUS_CONTROL, 32'hd7, r);
        rchk(ADDR_STATUS_CONTROL, 32'hd7, RESP_OKAY, "csc all");
        chk("ctrl pins", 32'h7, {29'h0, en, rsel, oe});
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_STATUS_CONTROL, 32'h90 | m, r);
            pin <= 1;
            repeat (5) @(posedge clk);
            x = 32'h98 | m | ((m % 2) ? 32'h20 : 32'h0);
            rchk(ADDR_STATUS_CONTROL, x, RESP_OKAY, "rise");
            chk("irq rise", m % 2, irq);
            wr(ADDR_STATUS_CONTROL, 32'hb0 | m, r);
            rchk(ADDR_STATUS_CONTROL, 32'h98 | m, RESP_OKAY, "w1c");
            pin <= 0;
            repeat (5) @(posedge clk);
            x = 32'h90 | m | ((m != 1) ? 32'h20 : 32'h0);
            rchk(ADDR_STATUS_CONTROL, x, RESP_OKAY, "fall");
            wr(ADDR_STATUS_CONTROL, 32'h90 | m, r);
            rchk(ADDR_STATUS_CONTROL, x, RESP_OKAY, "w0 keep");
            chk("irq fall", m != 1, irq);
            wr(ADDR_STATUS_CONTROL, 32'hb0 | m, r);
        end
        wr(ADDR_STATUS_CONTROL, 32'ha3, r);
        pin <= 1;
        repeat (5) @(posedge clk);
        rchk(ADDR_STATUS_CONTROL, 32'hab, RESP_OKAY, "flag no irq");
        chk("irq disabled", 0, irq);
        rchk(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY, "irq status");
        wr(ADDR_IRQ_MASK, 32'h1, r);
        rchk(ADDR_IRQ_MASK, 32'h1, RESP_OKAY, "irq mask");
        chk("irq unmasked", 1, irq);
        wr(ADDR_IRQ_STATUS, 32'h1, r);
        rchk(ADDR_IRQ_STATUS, 32'h2, RESP_OKAY, "irq cleared");
        chk("irq low", 0, irq);
        // disabled core reads zero even with the input high
        wr(ADDR_STATUS_CONTROL, 32'h24, r);
        repeat (5) @(posedge clk);
        rchk(ADDR_STATUS_CONTROL, 32'h04, RESP_OKAY, "off");
        chk("pin off", 0, opin);
        pin <= 0;
        refl <= 1;
        wr(ADDR_STATUS_CONTROL, 32'hc4, r);
        repeat (5) @(posedge clk);
        rchk(ADDR_STATUS_CONTROL, 32'hcc, RESP_OKAY, "ref sel");
        chk("pin on", 1, opin);
        wr(ADDR_STATUS_CONTROL, 32'h84, r);
        repeat (5) @(posedge clk);
        rchk(ADDR_STATUS_CONTROL, 32'ha4, RESP_OKAY, "pin sel");
        conclude();
    end
endmodule : ace_top_bench
